// [src/tss_pkg.sv]
// What this block does
// (R1) one-shot recipe event: each trigger runs the recipe once, then idles
// (R2) a recipe pass runs all sequences in order, all frames, all repeats
// (R3) sequence event: each trigger plays the next sequence, then waits
// (R4) sequence event: one trigger runs every repeat of that sequence
// (R5) single sequence: each trigger reruns it, never without a trigger
// (R6) several sequences: pointer steps per trigger, wraps after the last
// (R7) frame event: each trigger plays one frame, starting at the first
// (R8) frame event: after a sequence's last frame go to next sequence
// (R9) frame event, one sequence: after its last frame go back to first
// (R10) continuous: loop the recipe while the trigger input stays high
// (R11) continuous: on trigger drop finish the current pass, then halt
// (R12) free-run: loop forever while selected, trigger input ignored
// (R13) camera as master: other side sets one-shot with frame event
// (R14) event selection only applies in one-shot type
// (R15) all timing runs in one-microsecond steps
// (R16) other side keeps strobe and camera widths below frame time
// (R17) room for six recipes, ten sequences, twelve frames; pointers fit
// (R18) one-shot trigger is a synced rising edge; ignored while running
package tss_pkg;
  localparam int          N_REC      = 6;
  localparam int          N_SEQ      = 10;
  localparam int          N_FRM      = 12;
  localparam logic [11:0] A_CTRL     = 12'h000;
  localparam logic [11:0] A_FRMUS    = 12'h004;
  localparam logic [11:0] A_STAT     = 12'h008;
  localparam logic [11:0] A_NSEQ     = 12'h020;
  localparam logic [11:0] A_SCFG     = 12'h100;
  localparam int          C_TYPE     = 0;
  localparam int          C_EVT      = 2;
  localparam int          C_REC      = 4;
  localparam int          C_EN       = 8;
  localparam int          S_FRMS     = 0;
  localparam int          S_REPS     = 4;
  localparam logic [8:0]  CTRL_RST   = 9'h000;
  localparam logic [23:0] FRMUS_RST  = 24'h0061a8;
  localparam int          STEP_NS    = 1000;
  localparam int          PCLK_NS    = 4;
  localparam int          CYC_PER_US = STEP_NS / PCLK_NS;
  typedef enum logic [1:0] {TT_ONESHOT = 2'h0, TT_CONT = 2'h1, TT_FREE = 2'h2} tss_type_t;
  typedef enum logic [1:0] {EV_RECIPE = 2'h0, EV_SEQ = 2'h1, EV_FRAME = 2'h2} tss_evt_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1} tss_st_t;
  typedef enum logic [2:0] {
    RK_CTRL = 3'h0, RK_FRMUS = 3'h1, RK_STAT = 3'h2, RK_NSEQ = 3'h3, RK_SCFG = 3'h4, RK_NONE = 3'h7
  } tss_rk_t;
endpackage : tss_pkg

// [src/tss_sched.sv]
`timescale 1ns/1ps
module tss_sched import tss_pkg::*; #(
  parameter int NREC = N_REC,
  parameter int NSEQ = N_SEQ,
  parameter int NFRM = N_FRM
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trig_in,
  output logic             busy,
  output logic             frame_start,
  output logic      [3:0]  seq_idx,
  output logic      [3:0]  frame_idx
);

  // counts must fit the four-bit count fields and pointers; table index is seven bits
  if (NREC < 1 || NREC > 8) begin : g_chk_rec
    $error("tss_sched: recipe count out of range");
  end
  if (NSEQ < 1 || NSEQ > 15) begin : g_chk_seq
    $error("tss_sched: sequence count out of range");
  end
  if (NFRM < 1 || NFRM > 15) begin : g_chk_frm
    $error("tss_sched: frame count out of range");
  end
  if (NREC * NSEQ > 64) begin : g_chk_tab
    $error("tss_sched: sequence table too large");
  end
  // the microsecond prescaler is only eight bits wide
  if (CYC_PER_US < 1 || CYC_PER_US > 256) begin : g_chk_step
    $error("tss_sched: clock too fast for the step prescaler");
  end

  localparam int NT = NREC * NSEQ;

  typedef struct packed {
    tss_st_t              st;
    logic                 s1;
    logic                 s2;
    logic                 tp;
    logic [3:0]           seq;
    logic [3:0]           frm;
    logic [7:0]           rep;
    logic [7:0]           pre;
    logic [23:0]          us;
    logic                 fs;
    logic                 rdy;
    logic                 err;
    logic [31:0]          rdat;
    logic [8:0]           ctrl;
    logic [23:0]          fus;
    logic [NREC-1:0][3:0] nseq;
    logic [NT-1:0][11:0]  scfg;
  } tss_state_t;

  localparam tss_state_t RST = '{
    st: ST_IDLE, ctrl: CTRL_RST, fus: FRMUS_RST, default: '0
  };

  tss_state_t q;
  tss_state_t n;

  function automatic tss_rk_t dec_kind(input logic [11:0] a);
    tss_rk_t k;
    k = RK_NONE;
    if (a[1:0] != 2'h0) begin
      k = RK_NONE;
    end else if (a == A_CTRL) begin
      k = RK_CTRL;
    end else if (a == A_FRMUS) begin
      k = RK_FRMUS;
    end else if (a == A_STAT) begin
      k = RK_STAT;
    end else if (a >= A_NSEQ && a < A_NSEQ + 12'(4 * NREC)) begin
      k = RK_NSEQ;
    end else if (a >= A_SCFG && a < A_SCFG + 12'(4 * NT)) begin
      k = RK_SCFG;
    end
    return k;
  endfunction : dec_kind

  function automatic logic [6:0] dec_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[8:2];
  endfunction : dec_idx

  // zero or oversize counts fall back to the nearest legal one
  function automatic logic [3:0] lim(input logic [3:0] v, input int mx);
    logic [3:0] r;
    r = v;
    if (v == 4'h0) begin
      r = 4'h1;
    end else if (int'(v) > mx) begin
      r = 4'(mx);
    end
    return r;
  endfunction : lim

  function automatic logic [31:0] rd_word(input tss_rk_t kind, input tss_state_t s, input logic [6:0] idx);
    logic [31:0] w;
    w = 32'h0;
    case (kind)
      RK_CTRL:  w = {23'h0, s.ctrl};
      RK_FRMUS: w = {8'h00, s.fus};
      RK_STAT:  w = {14'h0, s.s2, s.rep, s.frm, s.seq, s.st[0]};
      RK_NSEQ:  w = {28'h0, s.nseq[idx[2:0]]};
      RK_SCFG:  w = {20'h0, s.scfg[idx]};
      default:  w = 32'h0;
    endcase
    return w;
  endfunction : rd_word

  // decides at a frame end whether playback halts or runs on
  function automatic logic pass_stop(input tss_type_t tt, input tss_evt_t ev, input logic lf, input logic lr,
                                     input logic ls, input logic held);
    logic s;
    s = 1'b1;
    case (tt)
      TT_ONESHOT: begin
        if (ev == EV_FRAME) begin
          s = 1'b1; // see (R7)
        end else if (ev == EV_SEQ) begin
          s = lf & lr; // see (R3) (R4) (R5)
        end else begin
          s = lf & lr & ls; // see (R1)
        end
      end
      TT_CONT:  s = lf & lr & ls & ~held; // see (R11)
      TT_FREE:  s = 1'b0; // see (R12)
      default:  s = 1'b1;
    endcase
    return s;
  endfunction : pass_stop

  logic [2:0]  rec;
  logic [6:0]  tidx;
  logic [11:0] cfg;
  logic [3:0]  nsq;
  logic [3:0]  nfr;
  logic [7:0]  nrp;
  logic [23:0] fus;
  logic        rise;
  logic        tick;
  logic        fend;
  logic        last_f;
  logic        last_r;
  logic        last_s;
  logic        go;
  logic        stop;
  logic        en;
  tss_type_t   ttype;
  tss_evt_t    tevt;
  tss_rk_t     k;
  logic [6:0]  ki;

  always_comb begin
    n     = q;
    n.fs  = 1'b0;
    n.s1  = trig_in;
    n.s2  = q.s1;
    n.tp  = q.s2;
    en    = q.ctrl[C_EN];
    ttype = tss_type_t'(q.ctrl[C_TYPE +: 2]);
    tevt  = tss_evt_t'(q.ctrl[C_EVT +: 2]);
    if (ttype != TT_ONESHOT) begin
      tevt = EV_RECIPE; // see (R14)
    end
    rec = q.ctrl[C_REC +: 3];
    if (int'(rec) >= NREC) begin
      rec = 3'h0;
    end
    tidx   = 7'(int'(rec) * NSEQ + int'(q.seq)); // see (R17)
    cfg    = q.scfg[tidx];
    nsq    = lim(q.nseq[rec], NSEQ);
    nfr    = lim(cfg[S_FRMS +: 4], NFRM);
    nrp    = (cfg[S_REPS +: 8] == 8'h00) ? 8'h01 : cfg[S_REPS +: 8];
    fus    = (q.fus == 24'h0) ? 24'h1 : q.fus;
    last_f = (q.frm >= nfr - 4'h1);
    last_r = (q.rep >= nrp - 8'h01) || (tevt == EV_FRAME);
    last_s = (q.seq >= nsq - 4'h1);
    rise   = q.s2 & ~q.tp; // see (R18)
    tick   = (q.pre == 8'(CYC_PER_US - 1)); // see (R15)
    fend   = (q.st == ST_RUN) && tick && (q.us >= fus - 24'h1);
    case (ttype)
      TT_ONESHOT: go = en & rise; // see (R1)
      TT_CONT:    go = en & q.s2; // see (R10)
      TT_FREE:    go = en; // see (R12)
      default:    go = 1'b0;
    endcase
    stop = 1'b0;
    case (q.st)
      ST_IDLE: begin
        // a trigger while running never reaches here, so it is dropped
        if (go) begin
          n.st  = ST_RUN;
          n.pre = 8'h00;
          n.us  = 24'h0;
          n.fs  = 1'b1;
          if (tevt == EV_RECIPE) begin
            n.seq = 4'h0; // see (R1)
            n.frm = 4'h0;
            n.rep = 8'h00;
          end else if (tevt == EV_SEQ) begin
            n.frm = 4'h0; // see (R3)
            n.rep = 8'h00;
          end
        end
      end
      ST_RUN: begin
        n.pre = tick ? 8'h00 : q.pre + 8'h01;
        if (tick) begin
          n.us = q.us + 24'h1;
        end
        if (!en) begin
          n.st = ST_IDLE;
        end else if (fend) begin
          n.us = 24'h0;
          if (!last_f) begin
            n.frm = q.frm + 4'h1; // see (R2) (R7)
          end else begin
            n.frm = 4'h0;
            if (last_r) begin
              n.rep = 8'h00;
              n.seq = last_s ? 4'h0 : q.seq + 4'h1; // see (R6) (R8) (R9)
            end else begin
              n.rep = q.rep + 8'h01; // see (R2) (R4)
            end
          end
          stop = pass_stop(ttype, tevt, last_f, last_r, last_s, q.s2); // see (R11)
          if (stop) begin
            n.st = ST_IDLE;
          end else begin
            n.fs = 1'b1;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // apb: setup edge loads the answer, access edge with pready commits
    k  = dec_kind(paddr);
    ki = (k == RK_NSEQ) ? dec_idx(paddr, A_NSEQ) : dec_idx(paddr, A_SCFG);
    n.rdy = psel & ~penable & ~q.rdy;
    // error flag lives only with pready so the output needs no gate
    n.err = 1'b0;
    if (psel && !penable && !q.rdy) begin
      n.err  = (k == RK_NONE);
      n.rdat = rd_word(k, q, ki);
    end
    if (psel && penable && q.rdy && pwrite) begin
      case (k)
        RK_CTRL: begin
          // a mode change aborts playback and rewinds the pointers
          n.ctrl = pwdata[8:0];
          n.st   = ST_IDLE;
          n.seq  = 4'h0;
          n.frm  = 4'h0;
          n.rep  = 8'h00;
          n.fs   = 1'b0;
        end
        RK_FRMUS: n.fus = pwdata[23:0];
        RK_NSEQ:  n.nseq[ki[2:0]] = pwdata[3:0];
        RK_SCFG:  n.scfg[ki] = pwdata[11:0];
        default:  n.err = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign prdata      = q.rdat;
  assign pready      = q.rdy;
  assign pslverr     = q.err;
  assign busy        = q.st[0];
  assign frame_start = q.fs;
  assign seq_idx     = q.seq;
  assign frame_idx   = q.frm;

endmodule : tss_sched

// [test/tss_sched_properties.sv]
`timescale 1ns/1ps
module tss_sched_properties import tss_pkg::*; #(
  parameter int NSEQ = N_SEQ,
  parameter int NFRM = N_FRM
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        trig_in,
  input wire logic        busy,
  input wire logic        frame_start,
  input wire logic [3:0]  seq_idx,
  input wire logic [3:0]  frame_idx
);
  logic [8:0] ctl_q;
  logic [7:0] gap_q;
  logic       wr_c;
  logic       one;
  logic       cont;
  logic       free;
  assign wr_c = psel && penable && pready && pwrite && paddr == A_CTRL;
  assign one  = ctl_q[1:0] == TT_ONESHOT && ctl_q[C_EN];
  assign cont = ctl_q[1:0] == TT_CONT && ctl_q[C_EN];
  assign free = ctl_q[1:0] == TT_FREE && ctl_q[C_EN];
  // gap saturates so the first frame after reset never looks early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 9'h000;
      gap_q <= 8'hff;
    end else if (ce) begin
      ctl_q <= wr_c ? pwdata[8:0] : ctl_q;
      gap_q <= frame_start ? 8'h00 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rise;
    $rose(trig_in) && !busy && one ##1 trig_in [*2];
  endsequence
  sequence s_held;
    trig_in [*4] ##0 (busy && cont && !wr_c);
  endsequence
  a_trig_start: assert property (s_rise |-> ##[1:4] busy)
    else $error("trigger did not start playback");
  a_no_self_start: assert property ($rose(busy) && one |-> $past(trig_in, 3))
    else $error("playback started without trigger");
  a_start_pulse: assert property ($rose(busy) |-> frame_start)
    else $error("run began without frame pulse");
  a_frame_space: assert property (frame_start && ce |-> gap_q >= 8'hf9)
    else $error("frame shorter than one step");
  a_cont_loop: assert property (s_held |=> busy)
    else $error("continuous loop stopped while held");
  a_free_loop: assert property (busy && free && !wr_c |=> busy)
    else $error("free run stopped");
  a_seq_range: assert property (seq_idx < 4'(NSEQ))
    else $error("sequence pointer out of range");
  a_frame_range: assert property (frame_idx < 4'(NFRM))
    else $error("frame pointer out of range");
endmodule : tss_sched_properties
bind tss_sched tss_sched_properties #(.NSEQ(NSEQ), .NFRM(NFRM)) tss_sched_properties_i (.*);

// [test/tss_trig_src.sv]
`timescale 1ns/1ps
module tss_trig_src (
  input  wire logic pclk,
  output logic      trig
);
  int hold = 0;
  // back to idle low once the hold runs out
  always @(posedge pclk) begin
    trig <= (hold > 0);
    if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  // a few cycles clear both sync stages
  // one-shot pulses kept far shorter than a frame; the continuous test holds 2000 cycles
  task automatic pulse(input int n);
    hold <= n;
  endtask : pulse
endmodule : tss_trig_src

// [test/tss_sched_test.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tss_sched_test import tss_pkg::*;;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, trig_in, busy, frame_start;
  logic [3:0]  seq_idx, frame_idx;
  int          mismatches = 0, samples_checked = 0, cyc = 0;
  tss_sched tss_sched_i (.*);
  tss_trig_src tss_trig_src_i (.pclk(pclk), .trig(trig_in));
  always #2 pclk = ~pclk;
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      give_verdict;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; if it never comes, only the bench timeout does
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("prdata", x, r)
    `CHK("pslverr", xe, e)
  endtask : rd
  // counts frames until idle; mid re-fires while busy to prove it is dropped
  task automatic play(input int hold, input int mid, output int nf, output logic [3:0] s0, output logic [3:0] f0);
    nf = 0;
    tss_trig_src_i.pulse(hold);
    for (int k = 0; k < 20000; k++) begin
      @(posedge pclk);
      if (k == mid) tss_trig_src_i.pulse(6);
      if (frame_start === 1'b1) begin
        if (nf == 0) begin
          s0 = seq_idx;
          f0 = frame_idx;
        end
        nf++;
      end
      if (k > 8 && busy === 1'b0) break;
    end
  endtask : play
  task automatic t_regs;
    rd(A_CTRL, 32'h0, 1'b0);
    rd(A_FRMUS, {8'h00, FRMUS_RST}, 1'b0);
    rd(A_STAT, 32'h0, 1'b0);
    rd(12'h00c, 32'h0, 1'b1);
    wr(A_FRMUS, 32'h1);
    wr(A_NSEQ, 32'h2);
    wr(A_SCFG, 32'h22);
    wr(A_SCFG + 12'h004, 32'h13);
    rd(A_SCFG, 32'h22, 1'b0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_recipe;
    int nf;
    logic [3:0] s, f;
    wr(A_CTRL, 32'h100);
    play(6, 300, nf, s, f);
    `CHK("recipe frames", 7, nf)
    repeat (400) @(posedge pclk);
    `CHK("idle after pass", 1'b0, busy)
    $display("test recipe done");
  endtask : t_recipe
  task automatic t_seq;
    int nf;
    logic [3:0] s, f;
    wr(A_CTRL, 32'h104);
    for (int i = 0; i < 3; i++) begin
      play(6, -1, nf, s, f);
      `CHK("seq frames", (i == 1) ? 3 : 4, nf)
      `CHK("seq index", 4'(i % 2), s)
    end
    rd(A_STAT, 32'h2, 1'b0);
    $display("test sequence done");
  endtask : t_seq
  task automatic t_frame(input int ns);
    int nf;
    logic [3:0] s, f, es, ef;
    es = 4'h0;
    ef = 4'h0;
    wr(A_NSEQ, 32'(ns));
    wr(A_CTRL, 32'h108);
    for (int i = 0; i < 6; i++) begin
      play(6, -1, nf, s, f);
      `CHK("frames per trigger", 1, nf)
      `CHK("frame seq", es, s)
      `CHK("frame idx", ef, f)
      ef = ef + 4'h1;
      if (ef == ((es == 4'h0) ? 4'h2 : 4'h3)) begin
        ef = 4'h0;
        es = (es + 4'h1 == 4'(ns)) ? 4'h0 : es + 4'h1;
      end
    end
    $display("test frame done");
  endtask : t_frame
  task automatic t_cont;
    int nf;
    logic [3:0] s, f;
    wr(A_NSEQ, 32'h2);
    wr(A_CTRL, 32'h101);
    play(2000, -1, nf, s, f);
    `CHK("continuous frames", 14, nf)
    $display("test continuous done");
  endtask : t_cont
  task automatic t_free;
    logic [3:0] f;
    wr(A_CTRL, 32'h102);
    repeat (2000) @(posedge pclk);
    `CHK("free run busy", 1'b1, busy)
    // one full frame time with the enable low must move nothing
    ce <= 1'b0;
    @(posedge pclk);
    f = frame_idx;
    repeat (CYC_PER_US) @(posedge pclk);
    `CHK("frozen frame", f, frame_idx)
    `CHK("frozen busy", 1'b1, busy)
    ce <= 1'b1;
    wr(A_CTRL, 32'h0);
    $display("test free done");
  endtask : t_free
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_recipe;
    t_seq;
    t_frame(2);
    t_frame(1);
    t_cont;
    t_free;
    give_verdict;
  end
endmodule : tss_sched_test
